//--- design/tms_pkg.sv
// Shared constants and types of the transfer mode supervisor
package tms_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_DLY_XFER = 12'h008;
    localparam logic [11:0] OFS_DLY_LOAD = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_BUILD_BIT = 2;
    localparam int CMD_TEST_LSB = 0;
    localparam int CMD_ENDDLY_BIT = 8;
    localparam int DLY_POST_LSB = 16;
    localparam int ST_POS_LSB = 0;
    localparam int ST_ENG_BIT = 2;
    localparam int ST_PROMPT_BIT = 3;
    localparam int ST_SHED_BIT = 4;
    localparam int ST_MANUAL_BIT = 5;
    localparam int ST_STATE_LSB = 8;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    localparam logic [31:0] DLY_XFER_RST = 32'h0000_0003;
    localparam logic [31:0] DLY_LOAD_RST = 32'h0002_0002;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_MAIN1 = 2'h1;
    localparam logic [1:0] SEL_MAIN2 = 2'h2;
    localparam logic [1:0] SEL_IOMOD = 2'h3;
    localparam logic [1:0] POS_OFF = 2'h0;
    localparam logic [1:0] POS_N = 2'h1;
    localparam logic [1:0] POS_E = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int FLASH_MS = 500;
    localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
    localparam int DLY_W = 16;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tms_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tms_apb_rsp_t;

    typedef struct packed {
        logic in1;
        logic in2;
        logic iom;
        logic key_auto;
        logic key_xfer;
        logic n_ok;
        logic e_ok;
    } tms_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TDLY,
        ST_WKEY,
        ST_PRE,
        ST_POST
    } tms_state_t;

endpackage

//--- design/tms_supervisor.sv
// Transfer mode supervisor: load shed, key switch handover and APB registers
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns

//Contract
//- Shed on emergency moves contactor to OFF at once, skipping delays.
//- Shed with normal available passes OFF, then connects normal.
//- Shed without normal holds OFF until normal returns or request withdrawn.
//- Shed while on normal causes no move by itself.
//- Normal lost during shed moves to OFF, never to emergency.
//- Shed in OFF reconnects normal as soon as it returns.
//- Shed withdrawn: normal with delays if available, else emergency.
//- Shed acts only on emergency-fed loads; preferred selector ignored.
//- Shed request is a contact on main input 1, 2 or I/O module.
//- Key has auto, manual and momentary handover; brief turn permits transfer.
//- Handover transfers only within a sequence an event already started.
//- Sequence runs delays and starts engine; delay-skip ends them.
//- Manual transfer awaiting handover shows prompt, flashes not-auto lamp.
//- Manual mode allows indefinite standby operation after normal returns.
//- Manual return to preferred needs handover, except automatic build retransfers on emergency loss.
//- Handover with both sources runs pre and post load delays.
//- Auto mode goes to standby on preferred loss, back on return.
//- Automatic build in manual: source loss still transfers automatically.
//- Automatic build in manual: test, peak shave, exercise still transfer.
//- Non-automatic build in manual: source loss causes no automatic transfer.
//- Non-automatic build in manual: tests ignored, transfer only on handover.
//- Handover never asserts engine start by itself.
module tms_supervisor #(
    parameter int TICK_CYCLES = tms_pkg::TICK_CYC,
    parameter int DLY_W = tms_pkg::DLY_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input tms_pkg::tms_apb_req_t apb_req,
    output tms_pkg::tms_apb_rsp_t apb_rsp,
    input tms_pkg::tms_pins_t pins,
    output logic [1:0] contactor_pos,
    output logic engine_start,
    output logic manual_prompt,
    output logic not_auto_led
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int TCW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 2) begin : g_chk_tick
        $error("TICK_CYCLES must be at least 2");
    end
    if (DLY_W < 1 || DLY_W > 16) begin : g_chk_dly
        $error("DLY_W must be 1 to 16");
    end
    if (tms_pkg::FLASH_TICKS < 1 || tms_pkg::FLASH_TICKS > 1023) begin : g_chk_flash
        $error("FLASH_TICKS must fit ten bits");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tms_pkg::tms_apb_rsp_t rsp_ff;
    tms_pkg::tms_pins_t s1_ff, s2_ff, s3_ff, pin_ff, nxt_pin;
    tms_pkg::tms_state_t state_ff, nxt_state;
    logic [1:0] sel_ff, pos_ff, nxt_pos, tgt_ff, nxt_tgt;
    logic [2:0] tests_ff, idx;
    logic [DLY_W-1:0] dly_xfer_ff, dly_pre_ff, dly_post_ff, tmr_ff, tmr_val;
    logic [TCW-1:0] tick_cnt_ff;
    logic [9:0] blink_cnt_ff;
    logic [31:0] rd_data;
    logic build_auto_ff, need_key_ff, nxt_key, tmr_load, blink_ff, key_prev_ff, eng_ff, prompt_ff, led_ff;
    logic acc, hit, wr_go, end_dly, tick, tmr_done, shed, manual, n_ok, e_ok;
    logic both_ok, tgt_ok, key_press, tests_eff, go_e, go_n, go_off, abort;

    assign apb_rsp = rsp_ff;
    assign contactor_pos = pos_ff;
    assign engine_start = eng_ff;
    assign manual_prompt = prompt_ff;
    assign not_auto_led = led_ff;

    // Register index from byte address, 3'h7 when unmapped
    function automatic logic [2:0] reg_idx(input logic [11:0] a);
        logic [2:0] r;
        r = 3'h7;
        case (a)
            tms_pkg::OFS_CTRL: r = 3'h0;
            tms_pkg::OFS_CMD: r = 3'h1;
            tms_pkg::OFS_DLY_XFER: r = 3'h2;
            tms_pkg::OFS_DLY_LOAD: r = 3'h3;
            tms_pkg::OFS_STATUS: r = 3'h4;
            default: r = 3'h7;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign acc = apb_req.psel & apb_req.penable;
    assign idx = reg_idx(apb_req.paddr);
    assign hit = (idx != 3'h7);
    assign wr_go = acc & rsp_ff.pready & apb_req.pwrite & hit;
    assign end_dly = wr_go & (idx == 3'h1) & apb_req.pwdata[tms_pkg::CMD_ENDDLY_BIT];

    always_comb begin
        rd_data = 32'h0000_0000;
        case (idx)
            3'h0: begin
                rd_data[tms_pkg::CTRL_SEL_LSB +: 2] = sel_ff;
                rd_data[tms_pkg::CTRL_BUILD_BIT] = build_auto_ff;
            end
            3'h1: rd_data[tms_pkg::CMD_TEST_LSB +: 3] = tests_ff;
            3'h2: rd_data[DLY_W-1:0] = dly_xfer_ff;
            3'h3: begin
                rd_data[DLY_W-1:0] = dly_pre_ff;
                rd_data[tms_pkg::DLY_POST_LSB +: DLY_W] = dly_post_ff;
            end
            3'h4: begin
                rd_data[tms_pkg::ST_POS_LSB +: 2] = pos_ff;
                rd_data[tms_pkg::ST_ENG_BIT] = eng_ff;
                rd_data[tms_pkg::ST_PROMPT_BIT] = prompt_ff;
                rd_data[tms_pkg::ST_SHED_BIT] = shed;
                rd_data[tms_pkg::ST_MANUAL_BIT] = manual;
                rd_data[tms_pkg::ST_STATE_LSB +: 3] = state_ff;
            end
            default: ;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rsp_ff <= '0;
        end else if (ce) begin
            rsp_ff.pready <= acc & ~rsp_ff.pready;
            if (acc & ~rsp_ff.pready) begin
                rsp_ff.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
                rsp_ff.pslverr <= ~hit;
            end else begin
                rsp_ff.pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff <= tms_pkg::CTRL_RST[tms_pkg::CTRL_SEL_LSB +: 2];
            build_auto_ff <= tms_pkg::CTRL_RST[tms_pkg::CTRL_BUILD_BIT];
            tests_ff <= 3'h0;
            dly_xfer_ff <= tms_pkg::DLY_XFER_RST[DLY_W-1:0];
            dly_pre_ff <= tms_pkg::DLY_LOAD_RST[DLY_W-1:0];
            dly_post_ff <= tms_pkg::DLY_LOAD_RST[tms_pkg::DLY_POST_LSB +: DLY_W];
        end else if (ce && wr_go) begin
            case (idx)
                3'h0: begin
                    sel_ff <= apb_req.pwdata[tms_pkg::CTRL_SEL_LSB +: 2];
                    build_auto_ff <= apb_req.pwdata[tms_pkg::CTRL_BUILD_BIT];
                end
                3'h1: tests_ff <= apb_req.pwdata[tms_pkg::CMD_TEST_LSB +: 3];
                3'h2: dly_xfer_ff <= apb_req.pwdata[DLY_W-1:0];
                3'h3: begin
                    dly_pre_ff <= apb_req.pwdata[DLY_W-1:0];
                    dly_post_ff <= apb_req.pwdata[tms_pkg::DLY_POST_LSB +: DLY_W];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and agreement filter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (ce) begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign nxt_pin = (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_ff <= '0;
            key_prev_ff <= 1'b0;
        end else if (ce) begin
            pin_ff <= nxt_pin;
            key_prev_ff <= pin_ff.key_xfer;
        end
    end

    // Shed source picked by the configured input
    always_comb begin
        case (sel_ff)
            tms_pkg::SEL_MAIN1: shed = pin_ff.in1;
            tms_pkg::SEL_MAIN2: shed = pin_ff.in2;
            tms_pkg::SEL_IOMOD: shed = pin_ff.iom;
            default: shed = 1'b0;
        endcase
    end

    assign manual = ~pin_ff.key_auto;
    assign n_ok = pin_ff.n_ok;
    assign e_ok = pin_ff.e_ok;
    assign both_ok = n_ok & e_ok;
    assign tgt_ok = (tgt_ff == tms_pkg::POS_N) ? n_ok : e_ok;
    assign key_press = pin_ff.key_xfer & ~key_prev_ff;

    // ----------------------------------------------------------------
    // Tick prescaler and delay timer
    // ----------------------------------------------------------------
    assign tick = (tick_cnt_ff == TCW'(TICK_CYCLES - 1));
    assign tmr_done = (tmr_ff == '0);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_ff <= '0;
        end else if (ce) begin
            tick_cnt_ff <= (tick || tmr_load) ? '0 : tick_cnt_ff + TCW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tmr_ff <= '0;
        end else if (ce) begin
            if (tmr_load) begin
                tmr_ff <= tmr_val;
            end else if (end_dly) begin
                tmr_ff <= '0;
            end else if (tick && !tmr_done) begin
                tmr_ff <= tmr_ff - DLY_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Transfer triggers
    // ----------------------------------------------------------------
    // Tests count unless a non-automatic build sits in manual
    assign tests_eff = (|tests_ff) & ~(manual & ~build_auto_ff);
    // Standby wanted on preferred loss or an effective test
    assign go_e = (pos_ff == tms_pkg::POS_N) & (~n_ok | tests_eff);
    // Back to preferred once it returns and no test holds standby
    assign go_n = (pos_ff == tms_pkg::POS_E) & n_ok & (~tests_eff | ~e_ok);
    assign go_off = (pos_ff == tms_pkg::POS_OFF) & (n_ok | e_ok);

    always_comb begin
        if (tgt_ff == tms_pkg::POS_N) begin
            abort = ~n_ok | ((pos_ff == tms_pkg::POS_E) & tests_eff & e_ok);
        end else begin
            abort = ((pos_ff == tms_pkg::POS_N) & n_ok & ~tests_eff) | ((pos_ff == tms_pkg::POS_OFF) & n_ok);
        end
    end

    // ----------------------------------------------------------------
    // Sequence state machine
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_pos = pos_ff;
        nxt_tgt = tgt_ff;
        nxt_key = need_key_ff;
        tmr_load = 1'b0;
        tmr_val = '0;
        if (shed) begin
            // Shed overrides any sequence; preferred selector plays no part
            nxt_state = tms_pkg::ST_IDLE;
            if (pos_ff == tms_pkg::POS_E) begin
                nxt_pos = tms_pkg::POS_OFF;
            end else if (pos_ff == tms_pkg::POS_OFF && n_ok) begin
                nxt_pos = tms_pkg::POS_N;
            end else if (pos_ff == tms_pkg::POS_N && !n_ok) begin
                nxt_pos = tms_pkg::POS_OFF;
            end
            // Otherwise hold: OFF without normal, or normal kept
        end else begin
            case (state_ff)
                tms_pkg::ST_IDLE: begin
                    if (go_off) begin
                        nxt_state = tms_pkg::ST_TDLY;
                        nxt_tgt = n_ok ? tms_pkg::POS_N : tms_pkg::POS_E;
                        nxt_key = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = dly_xfer_ff;
                    end else if (go_e) begin
                        nxt_state = tms_pkg::ST_TDLY;
                        nxt_tgt = tms_pkg::POS_E;
                        nxt_key = manual & ~build_auto_ff;
                        tmr_load = 1'b1;
                        tmr_val = dly_xfer_ff;
                    end else if (go_n) begin
                        nxt_state = tms_pkg::ST_TDLY;
                        nxt_tgt = tms_pkg::POS_N;
                        nxt_key = manual & (~build_auto_ff | e_ok);
                        tmr_load = 1'b1;
                        tmr_val = dly_xfer_ff;
                    end
                end
                tms_pkg::ST_TDLY: begin
                    if (abort) begin
                        nxt_state = tms_pkg::ST_IDLE;
                    end else if (tmr_done && tgt_ok) begin
                        if (need_key_ff) begin
                            nxt_state = tms_pkg::ST_WKEY;
                        end else begin
                            nxt_pos = tgt_ff;
                            nxt_state = tms_pkg::ST_IDLE;
                        end
                    end
                end
                tms_pkg::ST_WKEY: begin
                    if (abort) begin
                        nxt_state = tms_pkg::ST_IDLE;
                    end else if (key_press && both_ok) begin
                        nxt_state = tms_pkg::ST_PRE;
                        tmr_load = 1'b1;
                        tmr_val = dly_pre_ff;
                    end else if (key_press && tgt_ok) begin
                        nxt_pos = tgt_ff;
                        nxt_state = tms_pkg::ST_IDLE;
                    end
                end
                tms_pkg::ST_PRE: begin
                    if (abort) begin
                        nxt_state = tms_pkg::ST_IDLE;
                    end else if (tmr_done && tgt_ok) begin
                        nxt_pos = tgt_ff;
                        nxt_state = tms_pkg::ST_POST;
                        tmr_load = 1'b1;
                        tmr_val = dly_post_ff;
                    end
                end
                tms_pkg::ST_POST: begin
                    if (tmr_done) begin
                        nxt_state = tms_pkg::ST_IDLE;
                    end
                end
                default: nxt_state = tms_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= tms_pkg::ST_IDLE;
            pos_ff <= tms_pkg::POS_N;
            tgt_ff <= tms_pkg::POS_N;
            need_key_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            pos_ff <= nxt_pos;
            tgt_ff <= nxt_tgt;
            need_key_ff <= nxt_key;
        end
    end

    // ----------------------------------------------------------------
    // Engine start and operator indicators
    // ----------------------------------------------------------------
    // Engine start follows the sequence, the emergency position and tests, never the key
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            eng_ff <= 1'b0;
        end else if (ce) begin
            eng_ff <= ((nxt_state != tms_pkg::ST_IDLE) & (nxt_tgt == tms_pkg::POS_E))
                      | (nxt_pos == tms_pkg::POS_E) | tests_eff;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt_ff <= 10'h000;
            blink_ff <= 1'b0;
        end else if (ce && tick) begin
            if (blink_cnt_ff == 10'(tms_pkg::FLASH_TICKS - 1)) begin
                blink_cnt_ff <= 10'h000;
                blink_ff <= ~blink_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prompt_ff <= 1'b0;
            led_ff <= 1'b0;
        end else if (ce) begin
            prompt_ff <= (nxt_state == tms_pkg::ST_WKEY);
            led_ff <= manual & ((nxt_state != tms_pkg::ST_WKEY) | blink_ff);
        end
    end

endmodule

//--- verif/tms_checker.sv
// Port checker of the transfer mode supervisor
`timescale 1ns/1ns
module tms_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input tms_pkg::tms_apb_req_t apb_req,
    input tms_pkg::tms_apb_rsp_t apb_rsp,
    input tms_pkg::tms_pins_t pins,
    input wire logic [1:0] contactor_pos,
    input wire logic engine_start,
    input wire logic manual_prompt,
    input wire logic not_auto_led
);
    // ------------------------------------------------
    // Helper state
    // ------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [1:0] sel_ff;
    logic [3:0] shed_ff;
    logic [3:0] nok_ff;
    logic shed;
    logic map;
    assign shed = (sel_ff == 2'h1 && pins.in1) || (sel_ff == 2'h2 && pins.in2) || (sel_ff == 2'h3 && pins.iom);
    assign map = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= tms_pkg::OFS_STATUS;
    // Tracks the shed input selection written over the bus
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff <= 2'h0;
        end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
                     && apb_req.paddr == tms_pkg::OFS_CTRL) begin
            sel_ff <= apb_req.pwdata[1:0];
        end
    end
    // Saturating counts of cycles the shed request and normal source stand high
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shed_ff <= 4'h0;
            nok_ff <= 4'h0;
        end else begin
            shed_ff <= !shed ? 4'h0 : (shed_ff == 4'h8 ? 4'h8 : shed_ff + 4'h1);
            nok_ff <= !pins.n_ok ? 4'h0 : (nok_ff == 4'h8 ? 4'h8 : nok_ff + 4'h1);
        end
    end
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    sequence s_shed_on_e;
        $rose(shed) && contactor_pos == tms_pkg::POS_E;
    endsequence
    sequence s_off_reached;
        ##[1:8] contactor_pos == tms_pkg::POS_OFF;
    endsequence
    property p_rdy_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    property p_rdy_wait; apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready; endproperty
    property p_err_with_rdy; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
    property p_err_unmapped; apb_req.psel && apb_req.penable && apb_rsp.pready && !map |-> apb_rsp.pslverr; endproperty
    property p_shed_off; s_shed_on_e |-> s_off_reached; endproperty
    property p_shed_no_e; shed_ff == 4'h8 |-> contactor_pos != tms_pkg::POS_E; endproperty
    property p_shed_to_n;
        shed_ff == 4'h8 && nok_ff == 4'h8 && contactor_pos == tms_pkg::POS_OFF |-> ##[1:2] contactor_pos == tms_pkg::POS_N;
    endproperty
    property p_n_stays; contactor_pos == tms_pkg::POS_N && nok_ff == 4'h8 |=> contactor_pos != tms_pkg::POS_OFF; endproperty
    property p_eng_on_e; contactor_pos == tms_pkg::POS_E |-> engine_start; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    a_err_with_rdy: assert property (p_err_with_rdy) else $error("pslverr without pready");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    a_shed_off: assert property (p_shed_off) else $error("shed did not open contactor");
    a_shed_no_e: assert property (p_shed_no_e) else $error("emergency during shed");
    a_shed_to_n: assert property (p_shed_to_n) else $error("normal not restored");
    a_n_stays: assert property (p_n_stays) else $error("move to off from normal");
    a_eng_on_e: assert property (p_eng_on_e) else $error("engine start low on emergency");
endmodule

//--- verif/tms_field.sv
// Far-side model: source sensing, shed contact and key switch
`timescale 1ns/1ns
module tms_field (
    input wire logic clk_sys,
    input wire logic n_up,
    input wire logic e_up,
    input wire logic auto_up,
    input wire logic shed_up,
    input wire logic press,
    output tms_pkg::tms_pins_t pins
);
    logic [3:0] key_ff = 4'h0;
    // Momentary position springs back after a short turn
    always_ff @(posedge clk_sys) begin
        key_ff <= press ? 4'hA : (key_ff == 4'h0 ? 4'h0 : key_ff - 4'h1);
    end
    assign pins = '{shed_up, 1'b0, 1'b0, auto_up && key_ff == 4'h0, key_ff != 4'h0, n_up, e_up};
endmodule

//--- verif/tb_top.sv
// Self-checking bench of the transfer mode supervisor
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} tms_row_t;
    localparam logic [1:0] PO = tms_pkg::POS_OFF;
    localparam logic [1:0] PN = tms_pkg::POS_N;
    localparam logic [1:0] PE = tms_pkg::POS_E;
    logic clk_sys = 1'b0;
    logic reset_n;
    logic n_up, e_up, auto_up, shed_up, press;
    logic [1:0] pos;
    logic eng, prompt, led, e;
    logic [31:0] q;
    int fail_count = 0;
    int compares = 0;
    tms_pkg::tms_apb_req_t apb_req;
    tms_pkg::tms_apb_rsp_t apb_rsp;
    tms_pkg::tms_pins_t pins;
    tms_row_t rows [11] = '{
        '{1'b0, 12'h000, 32'h0, 32'h4, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h3, 1'b0},
        '{1'b0, 12'h00C, 32'h0, 32'h0002_0002, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h010, 32'hFF, 32'h0, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h1, 1'b0},
        '{1'b1, 12'h008, 32'h2, 32'h0, 1'b0}, '{1'b1, 12'h00C, 32'h0001_0001, 32'h0, 1'b0},
        '{1'b1, 12'h000, 32'h5, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'h5, 1'b0},
        '{1'b1, 12'h006, 32'h1, 32'h0, 1'b1}};
    always #4 clk_sys = ~clk_sys;
    tms_supervisor #(.TICK_CYCLES(4)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pins(pins), .contactor_pos(pos), .engine_start(eng), .manual_prompt(prompt),
        .not_auto_led(led));
    tms_field u_field (.clk_sys(clk_sys), .n_up(n_up), .e_up(e_up), .auto_up(auto_up), .shed_up(shed_up),
        .press(press), .pins(pins));
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic finish_test();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (apb_rsp.pready !== 1'b1 && i < 50);
        chk(i < 50, 1);
        if (i == 50) finish_test();
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic wait_pos(input logic [1:0] p);
        int i;
        for (i = 0; i < 300 && pos !== p; i++) @(posedge clk_sys);
        chk(pos, p);
        if (i == 300) finish_test();
    endtask
    task automatic kick();
        press <= 1'b1;
        @(posedge clk_sys);
        press <= 1'b0;
        repeat (60) @(posedge clk_sys);
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        apb_req = '0;
        reset_n = 1'b0;
        {n_up, e_up, auto_up, shed_up, press} = 5'b11100;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        foreach (rows[k]) begin
            apb(rows[k].wr, rows[k].a, rows[k].d);
            chk(q, rows[k].q);
            chk(e, rows[k].e);
        end
        n_up <= 1'b0;
        wait_pos(PE);
        chk(eng, 1);
        shed_up <= 1'b1;
        wait_pos(PO);
        repeat (40) @(posedge clk_sys);
        chk(pos, PO);
        n_up <= 1'b1;
        wait_pos(PN);
        repeat (40) @(posedge clk_sys);
        chk(pos, PN);
        n_up <= 1'b0;
        wait_pos(PO);
        repeat (40) @(posedge clk_sys);
        chk(pos, PO);
        shed_up <= 1'b0;
        wait_pos(PE);
        apb(1'b1, tms_pkg::OFS_CTRL, 32'h1);
        auto_up <= 1'b0;
        n_up <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk(pos, PE);
        chk(prompt, 1);
        shed_up <= 1'b1;
        wait_pos(PO);
        wait_pos(PN);
        shed_up <= 1'b0;
        apb(1'b1, tms_pkg::OFS_CMD, 32'h1);
        kick();
        chk(pos, PN);
        chk(eng, 0);
        n_up <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk(pos, PN);
        kick();
        wait_pos(PE);
        chk(led, 1);
        apb(1'b1, tms_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, tms_pkg::OFS_CMD, 32'h0);
        n_up <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk(pos, PE);
        kick();
        wait_pos(PN);
        apb(1'b1, tms_pkg::OFS_CMD, 32'h4);
        wait_pos(PE);
        e_up <= 1'b0;
        wait_pos(PN);
        finish_test();
    end
endmodule
bind tms_supervisor tms_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins(pins), .contactor_pos(contactor_pos), .engine_start(engine_start),
    .manual_prompt(manual_prompt), .not_auto_led(not_auto_led));
